// ### design/rsi_top.sv
/*
  reset-state initializer: picks the initial conditions of the chip for
  each reset cause, keeps the time-out and power-down flags, holds the
  processor until the values are applied and then releases it to fetch.
  assumes the watchdog, sleep and standby signals come from system-clock
  logic, and the external pin and low-voltage detector are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none

module rsi_top
  import rsi_pkg::*;
(
  // clock and reset
  input  wire logic   SYS_CLK,
  input  wire logic   RST_B,
  // reset sources
  input  wire logic   EXTERNAL_RESET_PIN_B,
  input  wire logic   LOW_VOLTAGE_RESET,
  input  wire logic   WDT_TIMEOUT,
  input  wire logic   STANDBY_MODE,
  // flag control from the processor
  input  wire logic   SLEEP_ENTER,
  input  wire logic   FLAGS_CLEAR,
  // status flags
  output var  logic   TIMEOUT_FLAG,
  output var  logic   POWER_DOWN_FLAG,
  // initial conditions to the chip
  output var  rsi_init_type INIT_STATE,
  output var  logic   INIT_STROBE,
  output var  logic   CPU_HOLD,
  output var  logic   FETCH_START,
  output var  logic   WDT_RUN
);

  // ----------------------------------------------------------------
  // source synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] src_sync;
  logic [SYNC_W-1:0] src_idle;

  // idle levels: pin high, low-voltage request low
  assign src_idle = SYNC_W'(1) << SYNC_PIN;

  rsi_sync i_rsi_sync (
    .clk        (SYS_CLK),
    .rst_b      (RST_B),
    .async_in   ({LOW_VOLTAGE_RESET, EXTERNAL_RESET_PIN_B}),
    .idle_level (src_idle),
    .sync_out   (src_sync)
  );

  logic pin_ev;
  logic wdt_ev;
  // pin is active low, inverted only after both flip-flops
  assign pin_ev = ~src_sync[SYNC_PIN] | src_sync[SYNC_LOW_VOLTAGE];
  assign wdt_ev = WDT_TIMEOUT;

  // ----------------------------------------------------------------
  // state and flags
  // ----------------------------------------------------------------
  rsi_state_type state;
  rsi_state_type next_state;
  rsi_kind_type  kind;
  rsi_kind_type  next_kind;
  logic          next_timeout_flag;
  logic          next_power_down_flag;
  rsi_init_type  next_init_state;
  logic          next_init_strobe;
  logic          next_cpu_hold;
  logic          next_fetch_start;
  logic          next_wdt_run;

  function automatic rsi_init_type init_for(input rsi_kind_type k);
    rsi_init_type v;
    v = INIT_IDLE;
    if (k == KIND_WDT_STBY) begin
      v.load_defaults = 1'b0;
      v.stack_ptr     = STACK_PTR_ZERO;
    end else begin
      v.load_defaults = 1'b1;
      v.int_enable    = INT_ENABLE_RST;
      v.timer_on      = 1'b0;
      v.wdt_clear     = 1'b1;
      v.port_data     = PORT_DATA_RST;
      v.port_dir      = PORT_DIR_RST;
      v.port_pullup   = PORT_PULLUP_RST;
      v.stack_ptr     = STACK_PTR_TOP;
    end
    v.program_counter_low_byte = PC_LOW_RST;
    return v;
  endfunction

  always_comb begin
    next_state           = state;
    next_kind            = kind;
    next_timeout_flag    = TIMEOUT_FLAG & ~FLAGS_CLEAR;
    next_power_down_flag = (POWER_DOWN_FLAG & ~FLAGS_CLEAR) | SLEEP_ENTER;
    next_init_state      = INIT_STATE;
    next_init_strobe     = 1'b0;
    next_cpu_hold        = CPU_HOLD;
    next_fetch_start     = 1'b0;
    next_wdt_run         = WDT_RUN;
    if (pin_ev) begin
      next_state = ST_APPLY;
      next_kind  = KIND_PIN;
      next_timeout_flag    = TIMEOUT_FLAG;
      next_power_down_flag = POWER_DOWN_FLAG;
    end else if (wdt_ev) begin
      next_state        = ST_APPLY;
      next_timeout_flag = 1'b1;
      if (STANDBY_MODE) begin
        next_kind            = KIND_WDT_STBY;
        next_power_down_flag = 1'b1;
      end else begin
        next_kind            = KIND_WDT_RUN;
        next_power_down_flag = POWER_DOWN_FLAG;
      end
    end else begin
      case (state)
        ST_RUN: begin
          next_state = ST_RUN;
        end
        ST_APPLY: begin
          next_state       = ST_RELEASE;
          next_init_state  = init_for(kind);
          next_init_strobe = 1'b1;
          next_wdt_run     = 1'b0;
        end
        ST_RELEASE: begin
          next_state       = ST_RUN;
          next_cpu_hold    = 1'b0;
          next_fetch_start = 1'b1;
          next_wdt_run     = 1'b1;
          next_init_state.wdt_clear = 1'b0;
        end
        default: begin
          next_state = ST_APPLY;
          next_kind  = KIND_POR;
        end
      endcase
    end
    if (next_state == ST_APPLY) begin
      next_cpu_hold = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      state           <= ST_APPLY;
      kind            <= KIND_POR;
      TIMEOUT_FLAG    <= 1'b0;
      POWER_DOWN_FLAG <= 1'b0;
      INIT_STATE      <= INIT_IDLE;
      INIT_STROBE     <= 1'b0;
      CPU_HOLD        <= 1'b1;
      FETCH_START     <= 1'b0;
      WDT_RUN         <= 1'b0;
    end else begin
      state           <= next_state;
      kind            <= next_kind;
      TIMEOUT_FLAG    <= next_timeout_flag;
      POWER_DOWN_FLAG <= next_power_down_flag;
      INIT_STATE      <= next_init_state;
      INIT_STROBE     <= next_init_strobe;
      CPU_HOLD        <= next_cpu_hold;
      FETCH_START     <= next_fetch_start;
      WDT_RUN         <= next_wdt_run;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  a_por_flags_zero: assert property ($rose(RST_B) |-> !TIMEOUT_FLAG && !POWER_DOWN_FLAG)
    else $error("flags not clear after power-on");
  a_pin_keeps_flags: assert property (pin_ev |=> $stable(TIMEOUT_FLAG) && $stable(POWER_DOWN_FLAG))
    else $error("pin reset changed flags");
  a_wdt_run_flags: assert property (!pin_ev && wdt_ev && !STANDBY_MODE |=>
    TIMEOUT_FLAG && $stable(POWER_DOWN_FLAG))
    else $error("run watchdog flags wrong");
  a_wdt_stby_flags: assert property (!pin_ev && wdt_ev && STANDBY_MODE |=>
    TIMEOUT_FLAG && POWER_DOWN_FLAG)
    else $error("standby watchdog flags wrong");
  a_full_defaults: assert property (INIT_STROBE && INIT_STATE.load_defaults |->
    INIT_STATE.port_dir == PORT_DIR_RST && INIT_STATE.port_data == PORT_DATA_RST &&
    INIT_STATE.port_pullup == PORT_PULLUP_RST && INIT_STATE.int_enable == INT_ENABLE_RST &&
    !INIT_STATE.timer_on && INIT_STATE.stack_ptr == STACK_PTR_TOP)
    else $error("default values wrong");
  a_stby_clears_sp: assert property (INIT_STROBE && !INIT_STATE.load_defaults |->
    INIT_STATE.stack_ptr == STACK_PTR_ZERO && INIT_STATE.program_counter_low_byte == PC_LOW_RST)
    else $error("standby reset pointers wrong");
  a_por_first_apply: assert property ($rose(RST_B) && !pin_ev && !wdt_ev |=>
    INIT_STROBE && INIT_STATE.load_defaults && INIT_STATE.wdt_clear)
    else $error("power-on defaults not applied");
  a_apply_then_fetch: assert property (INIT_STROBE && !pin_ev && !wdt_ev |=>
    FETCH_START && !CPU_HOLD && WDT_RUN)
    else $error("fetch did not follow apply");
  a_hold_before_fetch: assert property (FETCH_START |-> $past(CPU_HOLD) && $past(INIT_STROBE))
    else $error("fetch without prior hold");
  a_wdt_cleared_first: assert property (FETCH_START && $past(INIT_STATE.load_defaults) |->
    $past(INIT_STATE.wdt_clear))
    else $error("watchdog not cleared before run");

  c_por_release: cover property ($rose(RST_B) ##[1:4] FETCH_START);
  c_pin_reset: cover property (pin_ev ##[1:20] FETCH_START);
  c_wdt_run: cover property (wdt_ev && !STANDBY_MODE ##[1:4] FETCH_START);
  c_wdt_stby: cover property (wdt_ev && STANDBY_MODE ##[1:4] FETCH_START);

endmodule
`default_nettype wire

// ### design/rsi_pkg.sv
/*
  package of the reset-state initializer: widths, reset values and
  the record of initial conditions that goes out to the rest of the chip.
  assumes one system clock and a synchronous active-low power-on reset.
*/
package rsi_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned PORT_W  = 8;
  localparam int unsigned INT_W   = 8;
  localparam int unsigned SP_W    = 4;
  localparam int unsigned PC_LOW_W = 8;
  localparam int unsigned SYNC_W  = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PORT_W-1:0] PORT_DATA_RST   = 8'hFF;
  localparam logic [PORT_W-1:0] PORT_DIR_RST    = 8'hFF;
  localparam logic [PORT_W-1:0] PORT_PULLUP_RST = 8'h00;
  localparam logic [INT_W-1:0]  INT_ENABLE_RST  = 8'h00;
  localparam logic [SP_W-1:0]   STACK_PTR_TOP   = 4'hF;
  localparam logic [SP_W-1:0]   STACK_PTR_ZERO  = 4'h0;
  localparam logic [PC_LOW_W-1:0] PC_LOW_RST    = 8'h00;

  // ----------------------------------------------------------------
  // synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_PIN = 0;
  localparam int unsigned SYNC_LOW_VOLTAGE = 1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN     = 3'b001,
    ST_APPLY   = 3'b010,
    ST_RELEASE = 3'b100
  } rsi_state_type;

  typedef enum logic [1:0] {
    KIND_POR      = 2'h0,
    KIND_PIN      = 2'h1,
    KIND_WDT_RUN  = 2'h2,
    KIND_WDT_STBY = 2'h3
  } rsi_kind_type;

  typedef struct packed {
    logic              load_defaults;
    logic [INT_W-1:0]  int_enable;
    logic              timer_on;
    logic              wdt_clear;
    logic [PORT_W-1:0] port_data;
    logic [PORT_W-1:0] port_dir;
    logic [PORT_W-1:0] port_pullup;
    logic [SP_W-1:0]   stack_ptr;
    logic [PC_LOW_W-1:0] program_counter_low_byte;
  } rsi_init_type;

  localparam rsi_init_type INIT_IDLE = '{
    load_defaults: 1'b0, int_enable: INT_ENABLE_RST, timer_on: 1'b0,
    wdt_clear: 1'b0, port_data: PORT_DATA_RST, port_dir: PORT_DIR_RST,
    port_pullup: PORT_PULLUP_RST, stack_ptr: STACK_PTR_TOP,
    program_counter_low_byte: PC_LOW_RST};

endpackage

// ### design/rsi_sync.sv
/*
  two-stage synchroniser for reset-source pins.
  assumes inputs arrive from outside the system clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module rsi_sync
  import rsi_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // raw and synchronised levels
  input  wire logic [SYNC_W-1:0] async_in,
  input  wire logic [SYNC_W-1:0] idle_level,
  output var  logic [SYNC_W-1:0] sync_out
);

  logic [SYNC_W-1:0] stage1;
  logic [SYNC_W-1:0] next_stage1;
  logic [SYNC_W-1:0] next_sync_out;

  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_bit
      // both stages preload the idle level; raw levels pass through
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          stage1[g]   <= idle_level[g];
          sync_out[g] <= idle_level[g];
        end else begin
          stage1[g]   <= next_stage1[g];
          sync_out[g] <= next_sync_out[g];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### bench/rsi_top_tb.sv
/*
  testbench of the reset-state initializer: drives every reset source and
  checks the flags, the initial-condition record and the release sequence.
  assumes rsi_pkg and rsi_top are compiled before this file.
*/
`timescale 1ns/10ps
`default_nettype none

module rsi_top_tb;
  import rsi_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic         sys_clk     = 1'b0;
  logic         rst_b       = 1'b0;
  logic         pin_b       = 1'b1;
  logic         low_v       = 1'b0;
  logic         wdt         = 1'b0;
  logic         standby     = 1'b0;
  logic         sleep_enter = 1'b0;
  logic         flags_clear = 1'b0;
  logic         to_flag;
  logic         pd_flag;
  logic         strobe;
  logic         hold;
  logic         fetch;
  logic         wdt_run;
  rsi_init_type init;
  int           errors      = 0;
  int           check_count = 0;

  always #10 sys_clk = ~sys_clk;

  rsi_top i_rsi_top (
    .SYS_CLK              (sys_clk),
    .RST_B                (rst_b),
    .EXTERNAL_RESET_PIN_B (pin_b),
    .LOW_VOLTAGE_RESET    (low_v),
    .WDT_TIMEOUT          (wdt),
    .STANDBY_MODE         (standby),
    .SLEEP_ENTER          (sleep_enter),
    .FLAGS_CLEAR          (flags_clear),
    .TIMEOUT_FLAG         (to_flag),
    .POWER_DOWN_FLAG      (pd_flag),
    .INIT_STATE           (init),
    .INIT_STROBE          (strobe),
    .CPU_HOLD             (hold),
    .FETCH_START          (fetch),
    .WDT_RUN              (wdt_run)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flags(input logic t, input logic p);
    chk(16'(to_flag), 16'(t));
    chk(16'(pd_flag), 16'(p));
  endtask

  task automatic wait_for(input bit want_fetch);
    int n = 0;
    while (((want_fetch ? fetch : strobe) !== 1'b1) && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 40) begin
      errors++;
      conclude();
    end
  endtask

  // held at the strobe, freed at fetch
  task automatic strobe_and_release();
    wait_for(0);
    chk(16'(hold), 16'h0001);
    chk(16'(wdt_run), 16'h0000);
    wait_for(1);
    chk(16'(hold), 16'h0000);
    chk(16'(wdt_run), 16'h0001);
    chk(16'(init.wdt_clear), 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic power_on();
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    wait_for(0);
    chk_flags(1'b0, 1'b0);
    chk(16'(init.load_defaults), 16'h0001);
    chk(16'(init.wdt_clear), 16'h0001);
    chk(16'(init.int_enable), 16'h0000);
    chk(16'(init.timer_on), 16'h0000);
    chk(16'(init.port_data), 16'h00FF);
    chk(16'(init.port_dir), 16'h00FF);
    chk(16'(init.port_pullup), 16'h0000);
    chk(16'(init.stack_ptr), 16'h000F);
    chk(16'(init.program_counter_low_byte), 16'h0000);
    strobe_and_release();
  endtask

  task automatic sleep_then_clear();
    @(posedge sys_clk);
    sleep_enter <= 1'b1;
    @(posedge sys_clk);
    sleep_enter <= 1'b0;
    #1;
    chk_flags(1'b0, 1'b1);
    @(posedge sys_clk);
    flags_clear <= 1'b1;
    @(posedge sys_clk);
    flags_clear <= 1'b0;
    #1;
    chk_flags(1'b0, 1'b0);
  endtask

  task automatic watchdog(input logic in_standby);
    @(posedge sys_clk);
    standby <= in_standby;
    flags_clear <= 1'b1;
    @(posedge sys_clk);
    flags_clear <= 1'b0;
    wdt <= 1'b1;
    @(posedge sys_clk);
    wdt <= 1'b0;
    #1;
    chk_flags(1'b1, in_standby);
    chk(16'(hold), 16'h0001);
    wait_for(0);
    chk(16'(init.load_defaults), 16'(!in_standby));
    chk(16'(init.wdt_clear), 16'(!in_standby));
    chk(16'(init.program_counter_low_byte), 16'h0000);
    if (in_standby) begin
      chk(16'(init.stack_ptr), 16'h0000);
    end
    strobe_and_release();
    @(posedge sys_clk);
    standby <= 1'b0;
  endtask

  // pin or low-voltage reset, flags must survive
  task automatic external(input bit use_low_v);
    @(posedge sys_clk);
    pin_b <= use_low_v;
    low_v <= use_low_v;
    repeat (5) @(posedge sys_clk);
    #1;
    chk(16'(hold), 16'h0001);
    chk(16'(strobe), 16'h0000);
    @(posedge sys_clk);
    pin_b <= 1'b1;
    low_v <= 1'b0;
    wait_for(0);
    chk_flags(1'b1, 1'b1);
    chk(16'(init.load_defaults), 16'h0001);
    chk(16'(init.port_dir), 16'h00FF);
    strobe_and_release();
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    power_on();
    sleep_then_clear();
    watchdog(1'b0);
    watchdog(1'b1);
    external(1'b0);
    external(1'b1);
    power_on();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    conclude();
  end

endmodule

`default_nettype wire
